// ===== rcb_pkg.sv
// Purpose: constants and types of the cpu receive packet buffer
// Assumes: 200 MHz core clock, 125 us tdm frame
// Notes:   register map, channel config layout, timing counts
package rcb_pkg;
	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int NCH = 4;
	localparam int NBUF = 4;
	localparam int CHW = 2;
	localparam int BFW = 2;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_NS = 5;
	localparam int FRAME_NS = 125000;
	localparam int FRAME_CYC = FRAME_NS / CLK_NS;
	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [8:0] ADR_CH = 9'h000;
	localparam logic [8:0] ADR_BUF = 9'h080;
	localparam logic [8:0] ADR_FRAME = 9'h100;
	localparam logic [8:0] ADR_NONE = 9'h1ff;
	localparam logic [1:0] SUB_CFG = 2'h0;
	localparam logic [1:0] SUB_FILL = 2'h1;
	localparam logic [1:0] SUB_STAT = 2'h2;
	localparam logic [1:0] SUB_BASE = 2'h0;
	localparam logic [1:0] SUB_SIZE = 2'h1;
	localparam logic [1:0] SUB_WP = 2'h2;
	localparam logic [1:0] SUB_RP = 2'h3;
	// ----------------------------------------------------------------
	// channel config word fields
	// ----------------------------------------------------------------
	localparam int CF_MAX = 0;
	localparam int CF_MANT = 16;
	localparam int CF_EXP = 18;
	localparam int CF_HFE = 22;
	localparam int CF_CRA = 23;
	localparam int CF_CRB = 24;
	localparam int CF_BIDX = 25;
	localparam int ST_INIT = 16;
	localparam logic [31:0] CFG_RST = 32'h0004_0000;
	localparam logic [16:0] MAX_ZERO = 17'h10000;
	localparam logic [16:0] BUF_MIN = 17'h00100;
	localparam logic [3:0] SIZE_K_MAX = 4'h8;

	typedef enum logic [2:0] {
		S_IDLE,
		S_EVAL,
		S_STORE,
		S_DROP,
		S_REPORT
	} rcb_fsm_t;
endpackage : rcb_pkg

// ===== rcb_police.sv
// Purpose: leaky bucket check of one packet
// Assumes: fill kept in 1/64 byte, rate in 1/64 byte per frame
// Notes:   purely combinational, used once per packet
module rcb_police import rcb_pkg::*; (
	input  wire logic [23:0] fill_i,
	input  wire logic [15:0] delta_i,
	input  wire logic [1:0]  mant_i,
	input  wire logic [3:0]  exp_i,
	input  wire logic [15:0] max_i,
	input  wire logic [15:0] len_i,
	output logic      [23:0] fill_o,
	output logic             discard_o
);
	logic [18:0] rate;
	logic [34:0] drain;
	logic [23:0] drained;
	logic [24:0] sum;
	logic [22:0] limit;

	always_comb begin
		// 4 kbps = 4/64 byte per frame, so rate = (1.m << e) * 2
		rate = 19'({1'b1, mant_i, 15'h0000} >> (5'h10 - {1'b0, exp_i}));
		drain = 35'(delta_i) * 35'(rate);
		drained = (drain >= 35'(fill_i)) ? 24'h000000 : 24'(fill_i - drain);
		sum = 25'(drained) + 25'({len_i, 6'h00});
		limit = 23'({(max_i == 16'h0000) ? MAX_ZERO : 17'(max_i), 6'h00});
		discard_o = sum > 25'(limit);
		fill_o = discard_o ? drained : sum[23:0];
	end
endmodule : rcb_police

// ===== rcb_top.sv
// Purpose: store cpu-bound packets into circular buffers in memory
// Assumes: wishbone classic register slave, packet bytes on core clock
// Notes:   one packet in flight; read pointer belongs to software
//
// Decided for this implementation: the Wishbone slave port and the address map.
module rcb_top import rcb_pkg::*; #(
	parameter int FRAME_CYCLES = FRAME_CYC
) (
	input  wire logic            clk_i,
	input  wire logic            rst_i,
	input  wire logic            wb_cyc_i,
	input  wire logic            wb_stb_i,
	input  wire logic            wb_we_i,
	input  wire logic [31:0]     wb_adr_i,
	input  wire logic [3:0]      wb_sel_i,
	input  wire logic [31:0]     wb_dat_i,
	output logic      [31:0]     wb_dat_o,
	output logic                 wb_ack_o,
	input  wire logic            pkt_valid_i,
	input  wire logic            pkt_sop_i,
	input  wire logic            pkt_eop_i,
	input  wire logic [7:0]      pkt_data_i,
	input  wire logic [CHW-1:0]  pkt_chan_i,
	input  wire logic [15:0]     pkt_len_i,
	input  wire logic [15:0]     pkt_seq_i,
	input  wire logic [31:0]     pkt_ts_i,
	output logic                 pkt_ready_o,
	output logic                 mem_we_o,
	output logic      [31:0]     mem_addr_o,
	output logic      [7:0]      mem_data_o,
	output logic                 rep_valid_o,
	output logic      [CHW-1:0]  rep_chan_o,
	output logic                 rep_first_o,
	output logic                 rep_police_o,
	output logic                 rep_loss_o,
	output logic      [15:0]     rep_base_o,
	output logic      [15:0]     rep_len_o,
	output logic      [15:0]     rep_time_o,
	output logic                 cr_a_o,
	output logic                 cr_b_o,
	output logic      [15:0]     cr_seq_o,
	output logic      [31:0]     cr_ts_o,
	output logic                 alarm_o
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		rcb_fsm_t                   fsm;
		logic [15:0]                frame;
		logic [15:0]                div;
		logic [NCH-1:0][31:0]       ch_cfg;
		logic [NCH-1:0][23:0]       ch_fill;
		logic [NCH-1:0][15:0]       ch_time;
		logic [NCH-1:0]             ch_init;
		logic [NBUF-1:0][31:0]      bf_base;
		logic [NBUF-1:0][3:0]       bf_k;
		logic [NBUF-1:0][15:0]      bf_wp;
		logic [NBUF-1:0][15:0]      bf_rp;
		logic [CHW-1:0]             cur_ch;
		logic [BFW-1:0]             cur_bf;
		logic [15:0]                start;
		logic [15:0]                cnt;
		logic                       pol;
		logic                       loss;
		logic                       first;
		logic [15:0]                seq;
		logic [31:0]                ts;
		logic                       ack;
		logic [31:0]                rdat;
		logic                       ready;
		logic                       we;
		logic [31:0]                addr;
		logic [7:0]                 data;
		logic                       rep;
		logic                       cra;
		logic                       crb;
		logic                       alarm;
	} rcb_state_t;

	rcb_state_t st_q;
	rcb_state_t st_d;

	logic [23:0]      pol_fill;
	logic             pol_discard;
	logic [31:0]      cfg;
	logic [BFW-1:0]   bidx;
	logic [15:0]      mask;
	logic [16:0]      used;
	logic [16:0]      room;
	logic [15:0]      wp_inc;
	logic [NCH-1:0]   half;
	logic             take;

	// ----------------------------------------------------------------
	// current channel and buffer view
	// ----------------------------------------------------------------
	assign cfg = st_q.ch_cfg[st_q.cur_ch];
	assign bidx = cfg[CF_BIDX +: BFW];
	// size is 256 << k; k above 8 treated as 64K
	assign mask = 16'((BUF_MIN << ((st_q.bf_k[bidx] > SIZE_K_MAX) ?
		SIZE_K_MAX : st_q.bf_k[bidx])) - 17'h00001);
	// one byte stays unused so equal pointers always mean empty
	assign used = 17'((st_q.bf_wp[bidx] - st_q.bf_rp[bidx]) & mask);
	assign room = 17'(mask) - used;
	assign wp_inc = (st_q.bf_wp[bidx] + 16'h0001) & mask;
	assign take = pkt_valid_i && st_q.ready;

	rcb_police u_police (
		.fill_i    (st_q.ch_fill[st_q.cur_ch]),
		.delta_i   (st_q.frame - st_q.ch_time[st_q.cur_ch]),
		.mant_i    (cfg[CF_MANT +: 2]),
		.exp_i     (cfg[CF_EXP +: 4]),
		.max_i     (cfg[CF_MAX +: 16]),
		.len_i     (st_q.cnt),
		.fill_o    (pol_fill),
		.discard_o (pol_discard)
	);

	// ----------------------------------------------------------------
	// half-full detect per channel
	// ----------------------------------------------------------------
	for (genvar c = 0; c < NCH; c++) begin : g_half
		logic [BFW-1:0] b;
		logic [15:0]    m;
		logic [15:0]    u;
		assign b = st_q.ch_cfg[c][CF_BIDX +: BFW];
		assign m = 16'((BUF_MIN << ((st_q.bf_k[b] > SIZE_K_MAX) ?
			SIZE_K_MAX : st_q.bf_k[b])) - 17'h00001);
		assign u = (st_q.bf_wp[b] - st_q.bf_rp[b]) & m;
		assign half[c] = st_q.ch_cfg[c][CF_HFE] &&
			(17'(u) > ((17'(m) + 17'h00001) >> 1));
	end

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [8:0]     a;
		logic [1:0]     sub;
		logic [1:0]     idx;
		logic           wr;
		logic [31:0]    wd;
		// upper address bits set: map to a hole, no aliasing
		a = (|wb_adr_i[31:9]) ? ADR_NONE : wb_adr_i[8:0];
		sub = a[3:2];
		idx = a[5:4];
		wr = wb_cyc_i && wb_stb_i && st_q.ack && wb_we_i;
		wd = 32'h0000_0000;
		st_d = st_q;
		st_d.we = 1'b0;
		st_d.rep = 1'b0;
		st_d.cra = 1'b0;
		st_d.crb = 1'b0;
		st_d.alarm = |half;
		// frame tick divider
		if (st_q.div == 16'(FRAME_CYCLES - 1)) begin
			st_d.div = 16'h0000;
			st_d.frame = st_q.frame + 16'h0001;
		end else begin
			st_d.div = st_q.div + 16'h0001;
		end
		// wishbone slave, one wait state, ack for one cycle
		st_d.ack = wb_cyc_i && wb_stb_i && !st_q.ack;
		st_d.rdat = 32'h0000_0000;
		if (a[8:7] == ADR_CH[8:7] && !a[6]) begin
			if (sub == SUB_CFG) begin
				st_d.rdat = st_q.ch_cfg[idx];
				if (wr) st_d.ch_cfg[idx] = merge(st_q.ch_cfg[idx],
					wb_dat_i, wb_sel_i);
			end else if (sub == SUB_FILL) begin
				st_d.rdat = 32'(st_q.ch_fill[idx]);
				wd = merge(32'(st_q.ch_fill[idx]), wb_dat_i, wb_sel_i);
				if (wr) st_d.ch_fill[idx] = wd[23:0];
			end else if (sub == SUB_STAT) begin
				st_d.rdat = {15'h0000, st_q.ch_init[idx],
					st_q.ch_time[idx]};
				wd = merge(st_d.rdat, wb_dat_i, wb_sel_i);
				if (wr) begin
					st_d.ch_time[idx] = wd[15:0];
					st_d.ch_init[idx] = wd[ST_INIT];
				end
			end
		end else if (a[8:7] == ADR_BUF[8:7] && !a[6]) begin
			if (sub == SUB_BASE) begin
				st_d.rdat = st_q.bf_base[idx];
				if (wr) st_d.bf_base[idx] = merge(st_q.bf_base[idx],
					wb_dat_i, wb_sel_i);
			end else if (sub == SUB_SIZE) begin
				st_d.rdat = 32'(st_q.bf_k[idx]);
				wd = merge(32'(st_q.bf_k[idx]), wb_dat_i, wb_sel_i);
				if (wr) st_d.bf_k[idx] = wd[3:0];
			end else if (sub == SUB_WP) begin
				st_d.rdat = 32'(st_q.bf_wp[idx]);
				wd = merge(32'(st_q.bf_wp[idx]), wb_dat_i, wb_sel_i);
				if (wr) st_d.bf_wp[idx] = wd[15:0];
			end else begin
				st_d.rdat = 32'(st_q.bf_rp[idx]);
				wd = merge(32'(st_q.bf_rp[idx]), wb_dat_i, wb_sel_i);
				if (wr) st_d.bf_rp[idx] = wd[15:0];
			end
		end else if (a == ADR_FRAME) begin
			st_d.rdat = 32'(st_q.frame);
		end
		// packet engine; its updates override a same-cycle software write
		case (st_q.fsm)
			S_IDLE: begin
				if (pkt_valid_i && pkt_sop_i) begin
					st_d.cur_ch = pkt_chan_i;
					st_d.cnt = pkt_len_i;
					st_d.seq = pkt_seq_i;
					st_d.ts = pkt_ts_i;
					st_d.fsm = S_EVAL;
				end
			end
			S_EVAL: begin
				st_d.cur_bf = bidx;
				st_d.start = st_q.bf_wp[bidx];
				st_d.first = !st_q.ch_init[st_q.cur_ch];
				st_d.ch_init[st_q.cur_ch] = 1'b1;
				st_d.ch_time[st_q.cur_ch] = st_q.frame;
				st_d.ch_fill[st_q.cur_ch] = pol_fill;
				st_d.pol = pol_discard;
				st_d.loss = !pol_discard && (17'(st_q.cnt) > room);
				st_d.ready = 1'b1;
				st_d.fsm = (pol_discard || 17'(st_q.cnt) > room) ?
					S_DROP : S_STORE;
				st_d.cnt = 16'h0000;
			end
			S_STORE: begin
				if (take) begin
					st_d.we = 1'b1;
					st_d.addr = st_q.bf_base[st_q.cur_bf] +
						32'(st_q.bf_wp[st_q.cur_bf]);
					st_d.data = pkt_data_i;
					st_d.bf_wp[st_q.cur_bf] = wp_inc;
					st_d.cnt = st_q.cnt + 16'h0001;
					if (pkt_eop_i) begin
						st_d.ready = 1'b0;
						st_d.fsm = S_REPORT;
					end
				end
			end
			S_DROP: begin
				if (take && pkt_eop_i) begin
					st_d.ready = 1'b0;
					st_d.cnt = 16'h0000;
					st_d.fsm = S_REPORT;
				end
			end
			S_REPORT: begin
				st_d.rep = 1'b1;
				st_d.cra = !st_q.pol && !st_q.loss && cfg[CF_CRA];
				st_d.crb = !st_q.pol && !st_q.loss && cfg[CF_CRB];
				st_d.fsm = S_IDLE;
			end
			default: begin
				st_d.fsm = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= '0;
			st_q.fsm <= S_IDLE;
			st_q.ch_cfg <= {NCH{CFG_RST}};
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign wb_dat_o = st_q.rdat;
	assign wb_ack_o = st_q.ack;
	assign pkt_ready_o = st_q.ready;
	assign mem_we_o = st_q.we;
	assign mem_addr_o = st_q.addr;
	assign mem_data_o = st_q.data;
	assign rep_valid_o = st_q.rep;
	assign rep_chan_o = st_q.cur_ch;
	assign rep_first_o = st_q.first;
	assign rep_police_o = st_q.pol;
	assign rep_loss_o = st_q.loss;
	assign rep_base_o = st_q.start;
	assign rep_len_o = st_q.cnt;
	assign rep_time_o = st_q.frame;
	assign cr_a_o = st_q.cra;
	assign cr_b_o = st_q.crb;
	assign cr_seq_o = st_q.seq;
	assign cr_ts_o = st_q.ts;
	assign alarm_o = st_q.alarm;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_report_after_last: assert property (@(posedge clk_i) disable iff (rst_i)
		(st_q.fsm == S_STORE && take && pkt_eop_i) |=> ##1 rep_valid_o)
		else $error("report not issued after last byte");
	chk_wp_step: assert property (@(posedge clk_i) disable iff (rst_i)
		(st_q.fsm == S_STORE && take) |=> mem_we_o &&
		st_q.bf_wp[st_q.cur_bf] == $past(wp_inc))
		else $error("write pointer did not advance by one");
	chk_drop_silent: assert property (@(posedge clk_i) disable iff (rst_i)
		(st_q.fsm == S_DROP) |=> !mem_we_o)
		else $error("dropped packet written to memory");
	chk_police_route: assert property (@(posedge clk_i) disable iff (rst_i)
		(st_q.fsm == S_EVAL && pol_discard) |=> st_q.fsm == S_DROP &&
		st_q.pol && !st_q.loss)
		else $error("policed packet not dropped with flag");
	chk_loss_route: assert property (@(posedge clk_i) disable iff (rst_i)
		(st_q.fsm == S_EVAL && !pol_discard && 17'(st_q.cnt) > room)
		|=> st_q.fsm == S_DROP && st_q.loss)
		else $error("oversize packet not dropped as lost");
	chk_first_set: assert property (@(posedge clk_i) disable iff (rst_i)
		(st_q.fsm == S_EVAL && !st_q.ch_init[st_q.cur_ch]) |=>
		st_q.first && st_q.ch_init[st_q.cur_ch])
		else $error("first-packet flag not set");
	chk_recovery_ok: assert property (@(posedge clk_i) disable iff (rst_i)
		(cr_a_o || cr_b_o) |-> rep_valid_o && !rep_police_o && !rep_loss_o)
		else $error("recovery event for unstored packet");
	chk_alarm_cause: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(alarm_o) |-> $past(|half))
		else $error("alarm without half-full buffer");
	chk_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
endmodule : rcb_top

// ===== rcb_tb_mem.sv
// Purpose: external memory partner seen by the buffer write port
// Assumes: one byte per mem_we pulse, byte addressed
// Notes:   unwritten bytes read back as unknown so stale data fails
module rcb_tb_mem (
	input  wire logic        clk_i,
	input  wire logic        we_i,
	input  wire logic [31:0] addr_i,
	input  wire logic [7:0]  data_i,
	input  wire logic [31:0] look_i,
	output logic      [7:0]  look_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// storage and lookup
	// ----------------------------------------------------------------
	logic [7:0] mem [logic [31:0]];
	always @(posedge clk_i) begin
		if (we_i) begin
			mem[addr_i] = data_i;
		end
		look_o <= mem.exists(look_i) ? mem[look_i] : 8'hxx;
	end
endmodule : rcb_tb_mem

// ===== tb.sv
// Purpose: self-checking bench of the cpu receive packet buffer
// Assumes: frame shortened to 8 cycles, wishbone classic master
// Notes:   one packet at a time; software role played by the bench
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i, rst_i, cyc, stb, we, vld, sop, eop;
	logic [31:0] adr, dat, wb_dat_o, ts, mem_addr_o, look, q;
	logic [3:0]  sel;
	logic [7:0]  pdat, mem_data_o, look_o;
	logic [1:0]  chan, rep_chan_o;
	logic [15:0] plen, seq, rep_base_o, rep_len_o, cr_seq_o;
	logic [31:0] cr_ts_o;
	logic        wb_ack_o, pkt_ready_o, mem_we_o, rep_valid_o, rep_first_o;
	logic        rep_police_o, rep_loss_o, cr_a_o, cr_b_o, alarm_o, ra, rb;
	int          errors, samples_checked;
	int          tick_n;
	logic [15:0] rep_time_o;
	localparam int FRAME_T = 8;
	// ----------------------------------------------------------------
	// clock, reset, instances
	// ----------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	// cycles since reset release, for the expected frame count
	always @(posedge clk_i) begin
		if (rst_i) begin
			tick_n <= 0;
		end else begin
			tick_n <= tick_n + 1;
		end
	end
	rcb_top #(.FRAME_CYCLES(FRAME_T)) rcb_top_i (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pkt_valid_i(vld),
		.pkt_sop_i(sop), .pkt_eop_i(eop), .pkt_data_i(pdat),
		.pkt_chan_i(chan), .pkt_len_i(plen), .pkt_seq_i(seq),
		.pkt_ts_i(ts), .pkt_ready_o(pkt_ready_o), .mem_we_o(mem_we_o),
		.mem_addr_o(mem_addr_o), .mem_data_o(mem_data_o),
		.rep_valid_o(rep_valid_o), .rep_chan_o(rep_chan_o),
		.rep_first_o(rep_first_o), .rep_police_o(rep_police_o),
		.rep_loss_o(rep_loss_o), .rep_base_o(rep_base_o),
		.rep_len_o(rep_len_o), .rep_time_o(rep_time_o), .cr_a_o(cr_a_o),
		.cr_b_o(cr_b_o), .cr_seq_o(cr_seq_o), .cr_ts_o(cr_ts_o),
		.alarm_o(alarm_o));
	rcb_tb_mem rcb_tb_mem_i (
		.clk_i(clk_i), .we_i(mem_we_o), .addr_i(mem_addr_o),
		.data_i(mem_data_o), .look_i(look), .look_o(look_o));
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic fail(input string m);
		errors++;
		$display("[ERR] %0t %s", $time, m);
	endtask : fail
	task automatic chk(input logic [31:0] g, input logic [31:0] e,
			input string m);
		samples_checked++;
		if (g !== e) begin
			fail(m);
		end
	endtask : chk
	task automatic report_and_stop;
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : report_and_stop
	// one classic cycle; waits for ack, no assumed latency
	task automatic wb(input logic w, input logic [31:0] a,
			input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 100);
		if (n >= 100) begin
			fail("bus timeout");
		end
		q = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(q, e, "register read");
	endtask : rd
	task automatic send(input logic [1:0] c, input int len,
			input logic [7:0] d0);
		int i;
		int n;
		@(posedge clk_i);
		for (i = 0; i < len; i++) begin
			vld  <= 1'b1;
			sop  <= (i == 0);
			eop  <= (i == len - 1);
			pdat <= d0 + 8'(i);
			chan <= c;
			plen <= 16'(len);
			seq  <= 16'h0100 + 16'(len);
			ts   <= 32'hab00_0000 + 32'(len);
			n = 0;
			do begin
				@(posedge clk_i);
				n++;
			end while (pkt_ready_o !== 1'b1 && n < 50);
			if (n >= 50) begin
				fail("byte not taken");
			end
		end
		vld <= 1'b0;
		sop <= 1'b0;
		eop <= 1'b0;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (rep_valid_o !== 1'b1 && n < 50);
		if (n >= 50) begin
			fail("no report");
		end
		ra = cr_a_o;
		rb = cr_b_o;
	endtask : send
	task automatic er(input logic [15:0] b, input logic [15:0] l,
			input logic f, input logic p, input logic s);
		chk(rep_chan_o, chan, "report channel");
		chk(rep_first_o, f, "first flag");
		chk(rep_police_o, p, "police flag");
		chk(rep_loss_o, s, "loss flag");
		chk(rep_len_o, l, "report length");
		chk(rep_time_o, 32'(tick_n / FRAME_T), "report time");
		if (s == 1'b0 && p == 1'b0) begin
			chk(rep_base_o, b, "report offset");
		end
	endtask : er
	task automatic mk(input logic [31:0] a, input logic [7:0] e);
		look <= a;
		repeat (3) @(posedge clk_i);
		chk(look_o, e, "memory byte");
	endtask : mk
	task automatic cr(input logic a, input logic b);
		chk(ra, a, "event a");
		chk(rb, b, "event b");
		if (a | b) begin
			chk(cr_seq_o, seq, "event seq");
			chk(cr_ts_o, ts, "event stamp");
		end
	endtask : cr
	task automatic alm(input logic e);
		repeat (2) @(posedge clk_i);
		chk(alarm_o, e, "alarm level");
	endtask : alm
	// ----------------------------------------------------------------
	// watchdog and tests
	// ----------------------------------------------------------------
	initial begin
		repeat (20000) @(posedge clk_i);
		fail("watchdog");
		report_and_stop();
	end
	initial begin
		{cyc, stb, we, vld, sop, eop} = 6'h00;
		{adr, dat, ts, look, q} = '0;
		{pdat, chan, plen, seq} = '0;
		sel = 4'hf;
		errors = 0;
		samples_checked = 0;
		rst_i = 1'b1;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(32'h0000_0010, 32'h0004_0000);
		rd(32'h0000_0200, 32'h0000_0000);
		wb(1'b1, 32'h0000_0200, 32'hffff_ffff);
		rd(32'h0000_0200, 32'h0000_0000);
		// byte enables: only the second byte lane is replaced
		wb(1'b1, 32'h0000_00a0, 32'h1122_3344);
		sel <= 4'h2;
		wb(1'b1, 32'h0000_00a0, 32'haabb_ccdd);
		sel <= 4'hf;
		rd(32'h0000_00a0, 32'h1122_cc44);
		// buffer 0: 256 bytes, buffer 1: 512 bytes, pointers zeroed
		wb(1'b1, 32'h0000_0080, 32'h0000_1000);
		wb(1'b1, 32'h0000_0084, 32'h0000_0000);
		wb(1'b1, 32'h0000_0088, 32'h0000_0000);
		wb(1'b1, 32'h0000_008c, 32'h0000_0000);
		wb(1'b1, 32'h0000_0090, 32'h0000_2000);
		wb(1'b1, 32'h0000_0094, 32'h0000_0001);
		wb(1'b1, 32'h0000_0000, 32'h00c4_0000);
		wb(1'b1, 32'h0000_0010, 32'h0104_0000);
		wb(1'b1, 32'h0000_0020, 32'h0204_0001);
		wb(1'b1, 32'h0000_0024, 32'h0000_0000);
		send(2'h0, 4, 8'h10);
		er(16'd0, 16'd4, 1'b1, 1'b0, 1'b0);
		cr(1'b1, 1'b0);
		send(2'h1, 3, 8'h20);
		er(16'd4, 16'd3, 1'b1, 1'b0, 1'b0);
		cr(1'b0, 1'b1);
		mk(32'h0000_1003, 8'h13);
		mk(32'h0000_1004, 8'h20);
		send(2'h0, 130, 8'h40);
		er(16'd7, 16'd130, 1'b0, 1'b0, 1'b0);
		mk(32'h0000_1088, 8'hc1);
		alm(1'b1);
		send(2'h1, 120, 8'h30);
		er(16'd0, 16'd0, 1'b0, 1'b0, 1'b1);
		cr(1'b0, 1'b0);
		rd(32'h0000_0088, 32'h0000_0089);
		wb(1'b1, 32'h0000_008c, 32'h0000_0089);
		alm(1'b0);
		send(2'h0, 130, 8'h50);
		er(16'd137, 16'd130, 1'b0, 1'b0, 1'b0);
		mk(32'h0000_1089, 8'h50);
		mk(32'h0000_100a, 8'hd1);
		rd(32'h0000_0088, 32'h0000_000b);
		alm(1'b1);
		wb(1'b1, 32'h0000_008c, 32'h0000_000b);
		alm(1'b0);
		send(2'h2, 2, 8'h60);
		er(16'd0, 16'd0, 1'b1, 1'b1, 1'b0);
		rd(32'h0000_0024, 32'h0000_0000);
		send(2'h2, 1, 8'h70);
		er(16'd0, 16'd1, 1'b0, 1'b0, 1'b0);
		rd(32'h0000_0024, 32'h0000_0040);
		mk(32'h0000_2000, 8'h70);
		// eight frames drain 32 units only: still over the bucket
		repeat (64) @(posedge clk_i);
		send(2'h2, 1, 8'h71);
		er(16'd0, 16'd0, 1'b0, 1'b1, 1'b0);
		repeat (160) @(posedge clk_i);
		send(2'h2, 1, 8'h72);
		er(16'd1, 16'd1, 1'b0, 1'b0, 1'b0);
		mk(32'h0000_2001, 8'h72);
		// channel 3: mantissa 3, exponent 4, 56 units per frame
		wb(1'b1, 32'h0000_0030, 32'h0213_0001);
		send(2'h3, 1, 8'h80);
		er(16'd2, 16'd1, 1'b1, 1'b0, 1'b0);
		send(2'h3, 1, 8'h81);
		er(16'd0, 16'd0, 1'b0, 1'b1, 1'b0);
		// two frames at the faster rate empty the bucket again
		repeat (16) @(posedge clk_i);
		send(2'h3, 1, 8'h82);
		er(16'd3, 16'd1, 1'b0, 1'b0, 1'b0);
		mk(32'h0000_2003, 8'h82);
		report_and_stop();
	end
endmodule : tb
